// ==== accept_filter_core.sv ====
// Acceptance masks, mask select and buffer identifier bytes behind APB
//
// How it works
// - Receive buffer: id high byte read-only
// - Transmit buffer: id high byte read/write
// - Receive buffer: id low byte read-only
// - Buffer id bytes exist in modes 1, 2
// - Mask low bits 7-5 writable mask bits
// - Frame-type mask bit restricts frame type
// - Bits 4, 2 zero; bit 3 zero mode0
// - Mask extended high byte fully writable
// - Mask extended low byte fully writable
// - Four 2-bit mask-select fields, reset zero
// - Select codes: mask0, mask1, filter15, none
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module accept_filter_core
   import accept_pkg::*;
   #(
   parameter int NB = NBUF
   )
   (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire logic [ID_W-1:0] rx_id,
   input wire logic rx_ext,
   input wire logic rx_store,
   input wire logic [2:0] rx_store_buf,
   input wire logic [NFILT*ID_W-1:0] filter_id,
   input wire logic [NFILT-1:0] filter_ext,
   output logic [NFILT-1:0] match,
   output logic match_valid,
   output logic [NB*16-1:0] tx_ext_id,
   output logic [NB-1:0] buffer_direction_select,
   output logic enhanced_mode
   );

   // ==========================================================
   // APB handshake
   // ==========================================================
   logic pready_q; // One wait state, then answer
   logic pready_d;
   logic pslverr_q; // Unmapped address flag
   logic pslverr_d;
   logic [31:0] prdata_q; // Read data of the answer cycle
   logic [31:0] prdata_d;
   logic access; // Access phase in progress
   logic wr_go; // Write commits on this edge
   logic addr_hit; // Address decodes to a register
   logic [31:0] rdata; // Read value of current address

   assign access = psel & penable;
   // Write lands on the edge where pready is sampled high
   assign wr_go = access & pready_q & pwrite & addr_hit;

   // Answer after one wait state; data and error ride with it
   always_comb
   begin
      pready_d = access & ~pready_q;
      pslverr_d = access & ~pready_q & ~addr_hit;
      if (access && !pready_q && !pwrite)
      begin
         prdata_d = rdata;
      end
      else
      begin
         prdata_d = WORD_RST;
      end
   end

   // Handshake registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= WORD_RST;
      end
      else
      begin
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   // ==========================================================
   // Mode, direction and mask-select registers
   // ==========================================================
   logic [1:0] mode_q; // Operating mode
   logic [1:0] mode_d;
   logic [NB-1:0] dir_q; // 1 = buffer transmits
   logic [NB-1:0] dir_d;
   logic [7:0] msel_q; // Filters 15..12, two bits each
   logic [7:0] msel_d;
   logic enh; // Mode 1 or 2 active

   assign enh = (mode_q != MODE_LEGACY);

   // Plain read/write control words
   always_comb
   begin
      mode_d = mode_q;
      dir_d = dir_q;
      msel_d = msel_q;
      if (wr_go && paddr == OFF_MODE)
      begin
         mode_d = pwdata[1:0];
      end
      if (wr_go && paddr == OFF_DIR)
      begin
         dir_d = pwdata[NB-1:0];
      end
      if (wr_go && paddr == OFF_MSEL)
      begin
         msel_d = pwdata[7:0];
      end
   end

   // Control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_q <= MODE_RST;
         dir_q <= '0;
         msel_q <= BYTE_RST;
      end
      else
      begin
         mode_q <= mode_d;
         dir_q <= dir_d;
         msel_q <= msel_d;
      end
   end

   assign enhanced_mode = enh;
   assign buffer_direction_select = dir_q;

   // ==========================================================
   // Acceptance masks 0 and 1
   // ==========================================================
   logic [7:0] sidh_q [2]; // Standard mask bits 10..3
   logic [7:0] sidh_d [2];
   logic [7:0] sidl_q [2]; // Low byte with frame-type bit
   logic [7:0] sidl_d [2];
   logic [7:0] eidh_q [2]; // Extended mask bits 15..8
   logic [7:0] eidh_d [2];
   logic [7:0] eidl_q [2]; // Extended mask bits 7..0
   logic [7:0] eidl_d [2];
   logic [ID_W-1:0] mask_vec [2]; // Full 29-bit mask
   logic [1:0] extended_frame_filter_enable; // Effective frame-type mask bits

   // Mask writes; each mask sits in its own 16-byte slot
   always_comb
   begin
      for (int n = 0; n < 2; n++)
      begin
         sidh_d[n] = sidh_q[n];
         sidl_d[n] = sidl_q[n];
         eidh_d[n] = eidh_q[n];
         eidl_d[n] = eidl_q[n];
         if (wr_go && paddr == 12'(MASK_BASE + n * MASK_STRIDE + REG_SIDH))
         begin
            sidh_d[n] = pwdata[7:0];
         end
         if (wr_go && paddr == 12'(MASK_BASE + n * MASK_STRIDE + REG_SIDL))
         begin
            // Bits 4 and 2 never store; bit 3 only in modes 1, 2
            sidl_d[n] = pwdata[7:0] & SIDL_WMASK;
            sidl_d[n][EXTENDED_FRAME_FILTER_ENABLE_BIT] = enh ? pwdata[EXTENDED_FRAME_FILTER_ENABLE_BIT] : sidl_q[n][EXTENDED_FRAME_FILTER_ENABLE_BIT];
         end
         if (wr_go && paddr == 12'(MASK_BASE + n * MASK_STRIDE + REG_EIDH))
         begin
            eidh_d[n] = pwdata[7:0];
         end
         if (wr_go && paddr == 12'(MASK_BASE + n * MASK_STRIDE + REG_EIDL))
         begin
            eidl_d[n] = pwdata[7:0];
         end
      end
   end

   // Mask registers; power-on content is cleared, not left unknown
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int n = 0; n < 2; n++)
         begin
            sidh_q[n] <= BYTE_RST;
            sidl_q[n] <= BYTE_RST;
            eidh_q[n] <= BYTE_RST;
            eidl_q[n] <= BYTE_RST;
         end
      end
      else
      begin
         for (int n = 0; n < 2; n++)
         begin
            sidh_q[n] <= sidh_d[n];
            sidl_q[n] <= sidl_d[n];
            eidh_q[n] <= eidh_d[n];
            eidl_q[n] <= eidl_d[n];
         end
      end
   end

   // Assemble masks; frame-type bit is dead in mode 0
   always_comb
   begin
      for (int n = 0; n < 2; n++)
      begin
         mask_vec[n] = {sidh_q[n], sidl_q[n][7:5], sidl_q[n][1:0],
                        eidh_q[n], eidl_q[n]};
         extended_frame_filter_enable[n] = sidl_q[n][EXTENDED_FRAME_FILTER_ENABLE_BIT] & enh;
      end
   end

   // ==========================================================
   // Buffer identifier bytes
   // ==========================================================
   logic buf_sel; // Address lies in the buffer window
   logic [2:0] buf_idx; // Buffer addressed
   logic buf_low; // Low byte addressed
   logic [15:0] buf_word; // Word of the addressed buffer

   assign buf_sel = (paddr[ADDR_W-1:6] == BUF_BASE[ADDR_W-1:6])
                    && (paddr[5:3] < 3'(NB)) && (paddr[1:0] == 2'b00);
   assign buf_idx = paddr[5:3];
   assign buf_low = (paddr[2:0] == BUF_LOW[2:0]);

   // Storage filtered by direction and mode inside
   buffer_id_store #(
      .NB(NB)
   ) u_store (
      .pclk(pclk),
      .presetn(presetn),
      .sw_we(wr_go & buf_sel),
      .sw_buf(buf_idx),
      .sw_high(~buf_low),
      .sw_data(pwdata[7:0]),
      .dir(dir_q),
      .enhanced(enh),
      .rx_store(rx_store),
      .rx_buf(rx_store_buf),
      .rx_eid(rx_id[15:0]),
      .eid_flat(tx_ext_id)
   );

   assign buf_word = tx_ext_id[buf_idx*16 +: 16];

   // ==========================================================
   // Read decode
   // ==========================================================
   // Buffer bytes are unmapped in mode 0, so software sees an error
   always_comb
   begin
      rdata = WORD_RST;
      addr_hit = 1'b1;
      if (paddr == OFF_MODE)
      begin
         rdata[1:0] = mode_q;
      end
      else if (paddr == OFF_DIR)
      begin
         rdata[NB-1:0] = dir_q;
      end
      else if (paddr == OFF_MSEL)
      begin
         rdata[7:0] = msel_q;
      end
      else if (buf_sel && enh)
      begin
         if (buf_low)
         begin
            rdata[7:0] = buf_word[7:0];
         end
         else
         begin
            rdata[7:0] = buf_word[15:8];
         end
      end
      else
      begin
         addr_hit = 1'b0;
         for (int n = 0; n < 2; n++)
         begin
            if (paddr == 12'(MASK_BASE + n * MASK_STRIDE + REG_SIDH))
            begin
               rdata[7:0] = sidh_q[n];
               addr_hit = 1'b1;
            end
            if (paddr == 12'(MASK_BASE + n * MASK_STRIDE + REG_SIDL))
            begin
               rdata[7:0] = sidl_q[n] & SIDL_WMASK;
               rdata[EXTENDED_FRAME_FILTER_ENABLE_BIT] = extended_frame_filter_enable[n];
               addr_hit = 1'b1;
            end
            if (paddr == 12'(MASK_BASE + n * MASK_STRIDE + REG_EIDH))
            begin
               rdata[7:0] = eidh_q[n];
               addr_hit = 1'b1;
            end
            if (paddr == 12'(MASK_BASE + n * MASK_STRIDE + REG_EIDL))
            begin
               rdata[7:0] = eidl_q[n];
               addr_hit = 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Filter match for filters 12 to 15
   // ==========================================================
   logic [NFILT-1:0] hit; // Combinational per-filter result
   logic [NFILT-1:0] match_q; // Registered result
   logic [NFILT-1:0] match_d;
   logic match_valid_q; // Result strobe
   logic match_valid_d;

   // One comparator per filter; filter 15 doubles as a mask
   genvar f;
   generate
      for (f = 0; f < NFILT; f++)
      begin : g_filt
         id_compare u_cmp (
            .rx_id(rx_id),
            .rx_ext(rx_ext),
            .filt_id(filter_id[f*ID_W +: ID_W]),
            .filt_ext(filter_ext[f]),
            .mask0(mask_vec[0]),
            .mask1(mask_vec[1]),
            .mask_f15(filter_id[F15_IDX*ID_W +: ID_W]),
            .exiden0(extended_frame_filter_enable[0]),
            .exiden1(extended_frame_filter_enable[1]),
            .sel(msel_q[f*SEL_W +: SEL_W]),
            .hit(hit[f])
         );
      end
   endgenerate

   // Capture the verdict one cycle after the identifier strobe
   always_comb
   begin
      match_valid_d = rx_valid;
      match_d = rx_valid ? hit : match_q;
   end

   // Match registers; result holds until the next strobe
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         match_q <= '0;
         match_valid_q <= 1'b0;
      end
      else
      begin
         match_q <= match_d;
         match_valid_q <= match_valid_d;
      end
   end

   assign match = match_q;
   assign match_valid = match_valid_q;

endmodule

// ==== accept_filter_core_asserts.sv ====
// Concurrent checks on the ports of the acceptance block
`timescale 1ns/100ps
module accept_filter_core_asserts
   import accept_pkg::*;
   #(
   parameter int NB = NBUF
   )
   (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rx_valid,
   input wire logic [ID_W-1:0] rx_id,
   input wire logic rx_store,
   input wire logic [2:0] rx_store_buf,
   input wire logic [NFILT-1:0] match,
   input wire logic match_valid,
   input wire logic [NB*16-1:0] tx_ext_id,
   input wire logic [NB-1:0] buffer_direction_select,
   input wire logic enhanced_mode
   );
   // ===
   // Helpers
   // ===
   logic done; // Access completes this cycle
   logic inbuf; // Address hits the buffer window
   logic [2:0] bsel; // Buffer addressed
   logic [6:0] wpos; // Bit position of the addressed byte
   assign done = psel && penable && pready;
   assign inbuf = paddr >= 12'h040 && paddr <= 12'h06c;
   assign bsel = 3'((paddr - 12'h040) >> 3);
   // Low byte sits below the high byte in each slice
   assign wpos = {bsel, 4'h0} + (paddr[2] ? 7'h00 : 7'h08);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ===
   // Properties
   // ===
   property p_match_lat;
      rx_valid |=> match_valid;
   endproperty
   a_match_lat: assert property (p_match_lat) else $error("no match pulse");

   property p_match_hold;
      !rx_valid |=> $stable(match);
   endproperty
   a_match_hold: assert property (p_match_hold) else $error("match moved");

   property p_buf_map;
      done && inbuf |-> pslverr == !enhanced_mode;
   endproperty
   a_buf_map: assert property (p_buf_map) else $error("buffer map wrong");

   property p_rx_load;
      rx_store && enhanced_mode && !buffer_direction_select[rx_store_buf]
         |=> tx_ext_id[$past(rx_store_buf)*16 +: 16] == $past(rx_id[15:0]);
   endproperty
   a_rx_load: assert property (p_rx_load) else $error("rx id not stored");

   property p_rx_wr_ignore;
      done && pwrite && inbuf && !buffer_direction_select[bsel] && !rx_store
         |=> $stable(tx_ext_id);
   endproperty
   a_rx_wr_ignore: assert property (p_rx_wr_ignore) else $error("rx id written");

   property p_tx_rx_ignore;
      rx_store && buffer_direction_select[rx_store_buf] && !(psel && penable)
         |=> $stable(tx_ext_id);
   endproperty
   a_tx_rx_ignore: assert property (p_tx_rx_ignore) else $error("tx id overrun");

   property p_tx_wr;
      done && pwrite && inbuf && enhanced_mode && buffer_direction_select[bsel]
         |=> tx_ext_id[$past(wpos) +: 8] == $past(pwdata[7:0]);
   endproperty
   a_tx_wr: assert property (p_tx_wr) else $error("tx id not written");

   property p_sidl_read;
      done && !pwrite && (paddr == 12'h014 || paddr == 12'h024)
         |-> !prdata[4] && !prdata[2] && (enhanced_mode || !prdata[3]);
   endproperty
   a_sidl_read: assert property (p_sidl_read) else $error("mask low bits");

   // Main scenarios reached
   c_hit: cover property (rx_valid ##1 match != 4'h0);
   c_err: cover property (done && pslverr);
   c_load: cover property (rx_store && enhanced_mode);
endmodule

bind accept_filter_core accept_filter_core_asserts #(.NB(NB)) u_asserts (.pclk, .presetn,
   .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_id,
   .rx_store, .rx_store_buf, .match, .match_valid, .tx_ext_id, .buffer_direction_select,
   .enhanced_mode);

// ==== accept_filter_core_tb.sv ====
// Self-checking bench of the acceptance block against a behavioural model
`timescale 1ns/100ps
module accept_filter_core_tb
   import accept_pkg::*;
   ;
   // ===
   // Signals and model state
   // ===
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid, rx_ext;
   logic rx_store, match_valid, enhanced_mode;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [ID_W-1:0] rx_id;
   logic [2:0] rx_store_buf;
   logic [NFILT*ID_W-1:0] filter_id;
   logic [NFILT-1:0] filter_ext, match;
   logic [NBUF*16-1:0] tx_ext_id;
   logic [NBUF-1:0] buffer_direction_select;
   int bad_count, samples_checked;
   logic [1:0] mode_m = 2'h0; // Model mode
   logic [5:0] dir_m = 6'h00; // Model directions
   logic [7:0] msel_m = 8'h00; // Model mask select
   logic [7:0] mk[2][4] = '{default: 8'h00}; // Mask bytes
   logic [15:0] buf_m[6] = '{default: 16'h0000}; // Buffer ids

   accept_filter_core #(.NB(NBUF)) u_accept_filter_core (.pclk, .presetn, .paddr, .psel,
      .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_id, .rx_ext,
      .rx_store, .rx_store_buf, .filter_id, .filter_ext, .match, .match_valid, .tx_ext_id,
      .buffer_direction_select, .enhanced_mode);
   can_node_model u_can_node_model (.pclk, .rx_valid, .rx_id, .rx_ext, .rx_store,
      .rx_store_buf);

   initial pclk = 1'b0;
   always #10 pclk = ~pclk;

   // ===
   // Checking and verdict
   // ===
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (bad_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ===
   // Register model: {error, data}
   // ===
   function automatic logic [32:0] mdl_rd(input logic [11:0] a);
      logic [7:0] v;
      if (a == OFF_MODE) return 33'(mode_m);
      if (a == OFF_DIR) return 33'(dir_m);
      if (a == OFF_MSEL) return 33'(msel_m);
      if (a >= 12'h010 && a <= 12'h02c)
      begin
         v = mk[a[5:4] - 2'h1][a[3:2]];
         // Bits 4, 2 always zero; bit 3 hidden in mode 0
         if (a[3:2] == 2'h1) v &= (mode_m != 2'h0) ? 8'heb : 8'he3;
         return 33'(v);
      end
      if (a >= 12'h040 && a <= 12'h06c && mode_m != 2'h0)
         return 33'(a[2] ? buf_m[(a - 64) >> 3][7:0] : buf_m[(a - 64) >> 3][15:8]);
      return 33'h1_0000_0000;
   endfunction

   function automatic void mdl_wr(input logic [11:0] a, input logic [7:0] d);
      int b;
      b = (a - 64) >> 3;
      if (a == OFF_MODE) mode_m = d[1:0];
      if (a == OFF_DIR) dir_m = d[5:0];
      if (a == OFF_MSEL) msel_m = d;
      if (a >= 12'h010 && a <= 12'h02c)
         mk[a[5:4] - 2'h1][a[3:2]] = (a[3:2] == 2'h1 && mode_m == 2'h0) ?
            {d[7:4], mk[a[5:4] - 2'h1][1][3], d[2:0]} : d;
      if (a >= 12'h040 && a <= 12'h06c && mode_m != 2'h0 && dir_m[b])
      begin
         if (a[2]) buf_m[b][7:0] = d;
         else buf_m[b][15:8] = d;
      end
   endfunction

   // Expected hits of filters 12..15
   function automatic logic [3:0] mdl_match(input logic [28:0] id, input logic ext);
      logic [28:0] m;
      logic [1:0] s;
      logic ft;
      for (int k = 0; k < 4; k++)
      begin
         s = msel_m[2*k +: 2];
         m = (s == 2'h3) ? '1 : (s == 2'h2) ? filter_id[87 +: 29] : {mk[s[0]][0],
            mk[s[0]][1][7:5], mk[s[0]][1][1:0], mk[s[0]][2], mk[s[0]][3]};
         ft = s == 2'h3 || (!s[1] && mk[s[0]][1][3] && mode_m != 2'h0);
         // Standard frames compare the standard field only
         if (!ext) m[17:0] = '0;
         mdl_match[k] = ((id ^ filter_id[k*29 +: 29]) & m) == '0 && (!ft || ext == filter_ext[k]);
      end
   endfunction

   // ===
   // APB master: hold until pready, release after
   // ===
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      logic [32:0] e;
      int n;
      e = mdl_rd(a);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         #1;
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (n >= 16)
      begin
         bad_count++;
         give_verdict();
      end
      chk("pslverr", 32'(pslverr), 32'(e[32]));
      if (!wr) chk("prdata", prdata, e[31:0]);
      else mdl_wr(a, d[7:0]);
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ===
   // Main sequence
   // ===
   initial
   begin
      logic [31:0] v;
      logic [28:0] id;
      logic ext;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      filter_id = '0;
      filter_ext = '0;
      presetn = 1'b0;
      v = $urandom(72);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and mode 0 map, gaps and far address included
      for (int a = 0; a < 'h70; a += 4) apb(1'b0, 12'(a), 0);
      apb(1'b0, 12'hffc, 0);
      apb(1'b1, 12'h014, 32'hff);
      apb(1'b0, 12'h014, 0);
      apb(1'b1, OFF_MODE, 1);
      for (int a = 'h10; a < 'h30; a += 4)
      begin
         apb(1'b1, 12'(a), $urandom);
         apb(1'b0, 12'(a), 0);
      end
      // Both directions for every buffer
      for (int d = 0; d < 2; d++)
      begin
         apb(1'b1, OFF_DIR, d ? 32'h2a : 32'h15);
         for (int b = 0; b < 6; b++)
         begin
            apb(1'b1, 12'(64 + 8 * b), $urandom);
            apb(1'b1, 12'(68 + 8 * b), $urandom);
            u_can_node_model.load_buf(3'(b), 16'($urandom));
            if (!dir_m[b]) buf_m[b] = rx_id[15:0];
            #1;
            chk("tx_ext_id", 32'(tx_ext_id[16*b +: 16]), 32'(buf_m[b]));
            apb(1'b0, 12'(64 + 8 * b), 0);
            apb(1'b0, 12'(68 + 8 * b), 0);
         end
      end
      // Filter compares under every select code, both modes
      for (int i = 0; i < 240; i++)
      begin
         if (i % 30 == 0)
         begin
            apb(1'b1, OFF_MODE, (i < 180) ? 2 : 0);
            apb(1'b1, OFF_MSEL, (i < 120) ? {4{2'(i / 30)}} : $urandom);
            apb(1'b1, 12'h014, $urandom);
            apb(1'b1, 12'h024, $urandom);
         end
         @(posedge pclk);
         filter_id <= 116'({$urandom, $urandom, $urandom, $urandom});
         filter_ext <= 4'($urandom);
         #1;
         ext = 1'($urandom);
         id = filter_id[($urandom % 4) * 29 +: 29] ^ (29'(1) << ($urandom % 40));
         u_can_node_model.send_frame(id, ext);
         #1;
         chk("match_valid", 32'(match_valid), 32'h1);
         chk("match", 32'(match), 32'(mdl_match(id, ext)));
      end
      give_verdict();
   end
endmodule

// ==== accept_pkg.sv ====
// Shared offsets, field positions, reset values and codes of the acceptance block
package accept_pkg;

   // ===
   // Sizes
   // ===
   localparam int ADDR_W = 12; // APB address bits decoded
   localparam int ID_W = 29; // Standard 11 plus extended 18
   localparam int SID_W = 11; // Standard identifier bits
   localparam int NBUF = 6; // Buffers with extended id bytes
   localparam int NFILT = 4; // Filters 12 to 15
   localparam int SEL_W = 2; // Width of one mask-select field
   localparam int F15_IDX = 3; // Filter 15 within filters 12..15

   // ===
   // Register byte offsets
   // ===
   localparam logic [11:0] OFF_MODE = 12'h000;
   localparam logic [11:0] OFF_DIR = 12'h004;
   localparam logic [11:0] OFF_MSEL = 12'h008;
   localparam logic [11:0] MASK_BASE = 12'h010;
   localparam logic [11:0] MASK_STRIDE = 12'h010;
   localparam logic [11:0] REG_SIDH = 12'h000;
   localparam logic [11:0] REG_SIDL = 12'h004;
   localparam logic [11:0] REG_EIDH = 12'h008;
   localparam logic [11:0] REG_EIDL = 12'h00c;
   localparam logic [11:0] BUF_BASE = 12'h040;
   localparam logic [11:0] BUF_STRIDE = 12'h008;
   localparam logic [11:0] BUF_LOW = 12'h004;

   // ===
   // Field layout and reset values
   // ===
   localparam logic [7:0] SIDL_WMASK = 8'he3; // Bits 7-5 and 1-0
   localparam int EXTENDED_FRAME_FILTER_ENABLE_BIT = 3; // Frame-type mask bit
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] EID_RST = 16'h0000;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;

   // ===
   // Codes
   // ===
   typedef enum logic [1:0] {
      MODE_LEGACY = 2'b00,
      MODE_ENHANCED = 2'b01,
      MODE_FIFO = 2'b10
   } mode_e;

   typedef enum logic [1:0] {
      SEL_MASK0 = 2'b00,
      SEL_MASK1 = 2'b01,
      SEL_FILT15 = 2'b10,
      SEL_NONE = 2'b11
   } mask_sel_e;

endpackage

// ==== buffer_id_store.sv ====
// Extended identifier bytes of the transmit/receive buffers
`timescale 1ns/100ps
module buffer_id_store
   import accept_pkg::*;
   #(
   parameter int NB = NBUF
   )
   (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sw_we,
   input wire logic [2:0] sw_buf,
   input wire logic sw_high,
   input wire logic [7:0] sw_data,
   input wire logic [NB-1:0] dir,
   input wire logic enhanced,
   input wire logic rx_store,
   input wire logic [2:0] rx_buf,
   input wire logic [15:0] rx_eid,
   output logic [NB*16-1:0] eid_flat
   );

   // ==========================================================
   // One identifier word per buffer
   // ==========================================================
   genvar b;
   generate
      for (b = 0; b < NB; b++)
      begin : g_buf
         logic [15:0] eid_q; // High byte in 15:8, low in 7:0
         logic [15:0] eid_d;

         // Receiver loads only buffers set to receive
         always_comb
         begin
            eid_d = eid_q;
            if (enhanced && rx_store && rx_buf == 3'(b) && !dir[b])
            begin
               eid_d = rx_eid;
            end
            // Software owns the bytes only in transmit direction
            if (enhanced && sw_we && sw_buf == 3'(b) && dir[b])
            begin
               if (sw_high)
               begin
                  eid_d[15:8] = sw_data;
               end
               else
               begin
                  eid_d[7:0] = sw_data;
               end
            end
         end

         // Storage
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               eid_q <= EID_RST;
            end
            else
            begin
               eid_q <= eid_d;
            end
         end

         assign eid_flat[b*16 +: 16] = eid_q;
      end
   endgenerate

endmodule

// ==== can_node_model.sv ====
// Remote node model: presents received frames and identifier loads
`timescale 1ns/100ps
module can_node_model
   import accept_pkg::*;
   (
   input wire logic pclk,
   output logic rx_valid,
   output logic [ID_W-1:0] rx_id,
   output logic rx_ext,
   output logic rx_store,
   output logic [2:0] rx_store_buf
   );
   // ===
   // Idle levels
   // ===
   initial
   begin
      rx_valid = 1'b0;
      rx_id = '0;
      rx_ext = 1'b0;
      rx_store = 1'b0;
      rx_store_buf = 3'h0;
   end

   // One-cycle frame; idle id shows the inverse so stale copies never match
   task automatic send_frame(input logic [ID_W-1:0] id, input logic ext);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_id <= id;
      rx_ext <= ext;
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_id <= ~id;
      rx_ext <= ~ext;
   endtask

   // One-cycle load of a received identifier into a buffer
   task automatic load_buf(input logic [2:0] b, input logic [15:0] extended_identifier_bits);
      @(posedge pclk);
      rx_store <= 1'b1;
      rx_store_buf <= b;
      rx_id <= {~rx_id[28:16], extended_identifier_bits};
      @(posedge pclk);
      rx_store <= 1'b0;
      rx_store_buf <= ~b;
      rx_id <= ~rx_id;
   endtask
endmodule

// ==== id_compare.sv ====
// Identifier comparison of one filter under its selected mask
`timescale 1ns/100ps
module id_compare
   import accept_pkg::*;
   (
   input wire logic [ID_W-1:0] rx_id,
   input wire logic rx_ext,
   input wire logic [ID_W-1:0] filt_id,
   input wire logic filt_ext,
   input wire logic [ID_W-1:0] mask0,
   input wire logic [ID_W-1:0] mask1,
   input wire logic [ID_W-1:0] mask_f15,
   input wire logic exiden0,
   input wire logic exiden1,
   input wire logic [SEL_W-1:0] sel,
   output logic hit
   );

   // ==========================================================
   // Mask choice and compare
   // ==========================================================
   logic [ID_W-1:0] mask; // Mask after selection
   logic type_chk; // Frame type must match the filter
   logic [ID_W-1:0] diff; // Masked differing bits

   // Select mask, then compare only the bits it keeps
   always_comb
   begin
      mask = '1;
      type_chk = 1'b0;
      case (mask_sel_e'(sel))
         SEL_MASK0:
         begin
            mask = mask0;
            type_chk = exiden0;
         end
         SEL_MASK1:
         begin
            mask = mask1;
            type_chk = exiden1;
         end
         SEL_FILT15: mask = mask_f15;
         SEL_NONE:
         begin
            // Exact match, frame type included
            mask = '1;
            type_chk = 1'b1;
         end
         default: mask = '1;
      endcase
      diff = (rx_id ^ filt_id) & mask;
      // Standard frames carry no extended bits to compare
      if (!rx_ext)
      begin
         diff[ID_W-SID_W-1:0] = '0;
      end
      hit = (diff == '0) && (!type_chk || (rx_ext == filt_ext));
   end

endmodule
